/* File: design/mac_irq_regs.svh */
// Purpose: register offsets, field positions and reset values of the MAC status and interrupt block
// Assumes: 12-bit byte addresses on a 32-bit APB bus
// Notes: every offset is a byte address of one aligned word
`ifndef MAC_IRQ_REGS_SVH
`define MAC_IRQ_REGS_SVH

// register byte addresses
`define TX_STATUS_OFS 12'h014
`define IRQ_SOURCE_OFS 12'h024
`define IRQ_UNMASK_OFS 12'h028
`define IRQ_MASK_OFS 12'h02c
`define IRQ_MASK_BITS_OFS 12'h030

// transmit status bit positions
`define TX_UNDERRUN_BIT 6
`define TX_RETRY_BIT 2
`define TX_COLLISION_BIT 1

// interrupt source bit positions (same layout in the mask)
`define IRQ_PAUSE_ZERO_BIT 13
`define IRQ_PAUSE_RX_BIT 12
`define IRQ_RETRY_BIT 5
`define IRQ_UNDERRUN_BIT 4
`define IRQ_MGMT_DONE_BIT 0

// implemented bits and reset values
`define TX_VALID_MASK 32'h0000_0046
`define IRQ_VALID_MASK 32'h0000_3031
`define TX_STATUS_RST 32'h0000_0000
`define IRQ_SOURCE_RST 32'h0000_0000
`define IRQ_MASK_RST 32'h0000_3031
`define RDATA_IDLE 32'h0000_0000

`endif

/* File: design/mac_irq_pkg.sv */
// Purpose: shared types of the MAC status and interrupt block
// Assumes: 32-bit register words
// Notes: constants live in mac_irq_regs.svh
package mac_irq_pkg;
  typedef logic [31:0] word_t;
  typedef logic [11:0] addr_t;
endpackage

/* File: design/mac_tx_status_and_irq_logic.sv */
// Purpose: transmit status flags, interrupt source flags and mask of a 10/100 MAC, APB slave
// Assumes: event inputs are one-cycle pulses synchronous to CLK_IN (250 MHz)
// Notes: APB answers with exactly one wait state; outputs all come from flip-flops
//
// How it works
// R1: fifo read while empty sets tx bit 6, irq bit 4, bad CRC, tx error.
// R2: retry limit exceeded sets transmit status bit 2.
// R3: a collision on the medium sets transmit status bit 1.
// R4: writing one clears a transmit status flag, zero leaves it.
// R5: one interrupt line is high while any interrupt status bit is set.
// R6: events set their status bit only while the mask bit is clear.
// R7: a write to interrupt status loads each bit directly, ignoring the mask.
// R8: a read of interrupt status returns the bits then clears them.
// R9: after reset every source is masked.
// R10: ones written to the unmask port clear the matching mask bits.
// R11: ones written to the mask port set the matching mask bits.
// R12: unmask and mask ports store nothing, they only act on the mask.
// R13: hold-off countdown reaching zero sets interrupt status bit 13.
// R14: a valid pause frame received sets interrupt status bit 12.
// R15: retry limit exceeded sets interrupt status bit 5.
// R16: end of the PHY management shift sets interrupt status bit 0.
// R17: status bits 31 to 14 read zero and ignore writes.
// R18: mask has one bit per source at 13,12,5,4,0, resets to one, read-only.
// R19: an event in the same cycle as a clear wins.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "mac_irq_regs.svh"

module mac_tx_status_and_irq_logic (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic ARST_N_IN,
  // apb slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic PREADY_OUT,
  output logic [31:0] PRDATA_OUT,
  output logic PSLVERR_OUT,
  // hardware events, one-cycle pulses
  input wire logic TX_UNDERRUN_IN,
  input wire logic RETRY_LIMIT_IN,
  input wire logic COLLISION_IN,
  input wire logic HOLD_OFF_ZERO_IN,
  input wire logic PAUSE_RX_IN,
  input wire logic MGMT_DONE_IN,
  // transmitter side effects of an underrun
  output logic TX_ERR_OUT,
  output logic FORCE_BAD_CRC_OUT,
  // combined interrupt line to the pending register
  output logic ETH_IRQ_LINE_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_meta_ff;
  logic rst_n;

  // two stages so the release never lands near a clock edge
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rst_meta_ff <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n <= rst_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic acc_start;
  logic acc_done;
  logic wr_done;
  logic rd_done;
  logic addr_hit;
  logic pready_ff;
  mac_irq_pkg::word_t prdata_ff;
  logic pslverr_ff;

  // first access cycle fetches data, second one completes
  assign acc_start = PSEL_IN & PENABLE_IN & ~pready_ff;
  assign acc_done = PSEL_IN & PENABLE_IN & pready_ff;
  assign wr_done = acc_done & PWRITE_IN;
  assign rd_done = acc_done & ~PWRITE_IN;

  // mask read address is mapped, writes to it are simply ignored
  assign addr_hit = (PADDR_IN == `TX_STATUS_OFS) | (PADDR_IN == `IRQ_SOURCE_OFS) |
                    (PADDR_IN == `IRQ_UNMASK_OFS) | (PADDR_IN == `IRQ_MASK_OFS) |
                    (PADDR_IN == `IRQ_MASK_BITS_OFS);

  logic wr_tx;
  logic wr_irq;
  logic wr_unmask;
  logic wr_mask;
  logic rd_irq;

  assign wr_tx = wr_done & (PADDR_IN == `TX_STATUS_OFS);
  assign wr_irq = wr_done & (PADDR_IN == `IRQ_SOURCE_OFS);
  assign wr_unmask = wr_done & (PADDR_IN == `IRQ_UNMASK_OFS);
  assign wr_mask = wr_done & (PADDR_IN == `IRQ_MASK_OFS);
  assign rd_irq = rd_done & (PADDR_IN == `IRQ_SOURCE_OFS);

  ////////////////////////////////////////////////////////////////////////////
  // state

  mac_irq_pkg::word_t tx_status_flags_ff;
  mac_irq_pkg::word_t irq_source_flags_ff;
  mac_irq_pkg::word_t irq_mask_bits_ff;
  mac_irq_pkg::word_t nxt_tx_status_flags;
  mac_irq_pkg::word_t nxt_irq_source_flags;
  mac_irq_pkg::word_t nxt_irq_mask_bits;
  mac_irq_pkg::word_t tx_evt;
  mac_irq_pkg::word_t irq_evt;
  mac_irq_pkg::word_t irq_set;
  mac_irq_pkg::word_t irq_base;
  logic any_evt;
  logic tx_err_ff;
  logic bad_crc_ff;
  logic irq_line_ff;

  // event vectors placed at their register positions
  always_comb begin
    tx_evt = `TX_STATUS_RST;
    tx_evt[`TX_UNDERRUN_BIT] = TX_UNDERRUN_IN; // R1
    tx_evt[`TX_RETRY_BIT] = RETRY_LIMIT_IN; // R2
    tx_evt[`TX_COLLISION_BIT] = COLLISION_IN; // R3
    irq_evt = `IRQ_SOURCE_RST;
    irq_evt[`IRQ_PAUSE_ZERO_BIT] = HOLD_OFF_ZERO_IN; // R13
    irq_evt[`IRQ_PAUSE_RX_BIT] = PAUSE_RX_IN; // R14
    irq_evt[`IRQ_RETRY_BIT] = RETRY_LIMIT_IN; // R15
    irq_evt[`IRQ_UNDERRUN_BIT] = TX_UNDERRUN_IN; // R1
    irq_evt[`IRQ_MGMT_DONE_BIT] = MGMT_DONE_IN; // R16
  end

  assign any_evt = |irq_evt;

  // masked sources are dropped before they reach the status bits
  assign irq_set = irq_evt & ~irq_mask_bits_ff; // R6

  // transmit flags: write one clears, a same-cycle event still sets
  always_comb begin
    nxt_tx_status_flags = tx_status_flags_ff;
    if (wr_tx) begin
      nxt_tx_status_flags = tx_status_flags_ff & ~PWDATA_IN; // R4
    end
    nxt_tx_status_flags = (nxt_tx_status_flags | tx_evt) & `TX_VALID_MASK; // R19
  end

  // interrupt sources: the read clears only what the snapshot returned,
  // so an event during the wait state survives the clear
  always_comb begin
    irq_base = irq_source_flags_ff;
    if (wr_irq) begin
      irq_base = PWDATA_IN; // R7
    end else if (rd_irq) begin
      irq_base = irq_source_flags_ff & ~prdata_ff; // R8
    end
    nxt_irq_source_flags = (irq_base | irq_set) & `IRQ_VALID_MASK; // R17 R19
  end

  // the two ports are decoded strobes, there is no storage behind them
  always_comb begin
    nxt_irq_mask_bits = irq_mask_bits_ff;
    if (wr_unmask) begin
      nxt_irq_mask_bits = nxt_irq_mask_bits & ~PWDATA_IN; // R10 R12
    end
    if (wr_mask) begin
      nxt_irq_mask_bits = nxt_irq_mask_bits | PWDATA_IN; // R11 R12
    end
    nxt_irq_mask_bits = nxt_irq_mask_bits & `IRQ_VALID_MASK; // R18
  end

  // transmit status register
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      tx_status_flags_ff <= `TX_STATUS_RST;
    end else begin
      tx_status_flags_ff <= nxt_tx_status_flags;
    end
  end

  // interrupt source register and its combined line, updated together
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      irq_source_flags_ff <= `IRQ_SOURCE_RST;
      irq_line_ff <= 1'b0;
    end else begin
      irq_source_flags_ff <= nxt_irq_source_flags;
      irq_line_ff <= |nxt_irq_source_flags; // R5
    end
  end

  // mask register, all sources masked out of reset
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_bits_ff <= `IRQ_MASK_RST; // R9 R18
    end else begin
      irq_mask_bits_ff <= nxt_irq_mask_bits;
    end
  end

  // underrun side effects last one cycle; the transmitter stretches them per frame
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      tx_err_ff <= 1'b0;
      bad_crc_ff <= 1'b0;
    end else begin
      tx_err_ff <= TX_UNDERRUN_IN; // R1
      bad_crc_ff <= TX_UNDERRUN_IN; // R1
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus answer

  // one fixed wait state keeps read data registered
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= acc_start;
      pslverr_ff <= acc_start & ~addr_hit;
    end
  end

  // read mux; write-only ports and unmapped words read zero
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      prdata_ff <= `RDATA_IDLE;
    end else if (acc_start & ~PWRITE_IN) begin
      case (PADDR_IN)
        `TX_STATUS_OFS: prdata_ff <= tx_status_flags_ff;
        `IRQ_SOURCE_OFS: prdata_ff <= irq_source_flags_ff; // R17
        `IRQ_MASK_BITS_OFS: prdata_ff <= irq_mask_bits_ff; // R18
        default: prdata_ff <= `RDATA_IDLE;
      endcase
    end else if (acc_start) begin
      prdata_ff <= `RDATA_IDLE;
    end
  end

  assign PREADY_OUT = pready_ff;
  assign PRDATA_OUT = prdata_ff;
  assign PSLVERR_OUT = pslverr_ff;
  assign TX_ERR_OUT = tx_err_ff;
  assign FORCE_BAD_CRC_OUT = bad_crc_ff;
  assign ETH_IRQ_LINE_OUT = irq_line_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!rst_n);

  sequence s_underrun;
    TX_UNDERRUN_IN;
  endsequence

  sequence s_underrun_seen;
    tx_status_flags_ff[`TX_UNDERRUN_BIT] && TX_ERR_OUT && FORCE_BAD_CRC_OUT;
  endsequence

  property p_underrun;
    s_underrun |=> s_underrun_seen;
  endproperty
  a_underrun: assert property (p_underrun) else $error("underrun not flagged"); // R1
  property p_retry_tx;
    RETRY_LIMIT_IN |=> tx_status_flags_ff[`TX_RETRY_BIT];
  endproperty
  a_retry_tx: assert property (p_retry_tx) else $error("retry flag missing"); // R2
  property p_collision;
    COLLISION_IN |=> tx_status_flags_ff[`TX_COLLISION_BIT];
  endproperty
  a_collision: assert property (p_collision) else $error("collision flag missing"); // R3
  property p_tx_w1c;
    wr_tx && PWDATA_IN[`TX_COLLISION_BIT] && !COLLISION_IN |=> !tx_status_flags_ff[`TX_COLLISION_BIT];
  endproperty
  a_tx_w1c: assert property (p_tx_w1c) else $error("write one did not clear"); // R4
  property p_tx_w0;
    wr_tx && !PWDATA_IN[`TX_RETRY_BIT] && tx_status_flags_ff[`TX_RETRY_BIT]
      |=> tx_status_flags_ff[`TX_RETRY_BIT];
  endproperty
  a_tx_w0: assert property (p_tx_w0) else $error("write zero cleared a flag"); // R4
  property p_irq_line;
    ETH_IRQ_LINE_OUT == (|irq_source_flags_ff);
  endproperty
  a_irq_line: assert property (p_irq_line) else $error("irq line disagrees with status"); // R5
  property p_masked;
    PAUSE_RX_IN && irq_mask_bits_ff[`IRQ_PAUSE_RX_BIT] && !wr_irq && !rd_irq
      |=> $stable(irq_source_flags_ff[`IRQ_PAUSE_RX_BIT]);
  endproperty
  a_masked: assert property (p_masked) else $error("masked event changed status"); // R6

  property p_sw_write;
    wr_irq && !any_evt |=> irq_source_flags_ff == ($past(PWDATA_IN) & `IRQ_VALID_MASK);
  endproperty
  a_sw_write: assert property (p_sw_write) else $error("status write not loaded"); // R7

  sequence s_quiet_read;
    (acc_start && !PWRITE_IN && PADDR_IN == `IRQ_SOURCE_OFS && !any_evt) ##1 (rd_irq && !any_evt);
  endsequence

  property p_read_clear;
    s_quiet_read |=> irq_source_flags_ff == `IRQ_SOURCE_RST;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read did not clear status"); // R8

  property p_read_value;
    s_quiet_read |-> PRDATA_OUT == $past(irq_source_flags_ff);
  endproperty
  a_read_value: assert property (p_read_value) else $error("read returned wrong status"); // R8

  property p_reset_mask;
    $rose(rst_n) |-> irq_mask_bits_ff == `IRQ_MASK_RST;
  endproperty
  a_reset_mask: assert property (p_reset_mask) else $error("mask not set after reset"); // R9

  property p_unmask;
    wr_unmask && !wr_mask |=> (irq_mask_bits_ff & $past(PWDATA_IN)) == `IRQ_SOURCE_RST;
  endproperty
  a_unmask: assert property (p_unmask) else $error("unmask port failed"); // R10

  property p_mask;
    wr_mask |=> (irq_mask_bits_ff & `IRQ_VALID_MASK) == (($past(PWDATA_IN) | $past(irq_mask_bits_ff))
      & `IRQ_VALID_MASK);
  endproperty
  a_mask: assert property (p_mask) else $error("mask port failed"); // R11

  property p_no_storage;
    (PADDR_IN == `IRQ_UNMASK_OFS) && acc_start && !PWRITE_IN |=> PRDATA_OUT == `RDATA_IDLE;
  endproperty
  a_no_storage: assert property (p_no_storage) else $error("strobe port read nonzero"); // R12

  property p_hold_off;
    HOLD_OFF_ZERO_IN && !irq_mask_bits_ff[`IRQ_PAUSE_ZERO_BIT] |=> irq_source_flags_ff[`IRQ_PAUSE_ZERO_BIT];
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("countdown zero lost"); // R13 R19

  property p_pause_rx;
    PAUSE_RX_IN && !irq_mask_bits_ff[`IRQ_PAUSE_RX_BIT] |=> irq_source_flags_ff[`IRQ_PAUSE_RX_BIT];
  endproperty
  a_pause_rx: assert property (p_pause_rx) else $error("pause frame lost"); // R14 R19

  property p_retry_irq;
    RETRY_LIMIT_IN && !irq_mask_bits_ff[`IRQ_RETRY_BIT] |=> irq_source_flags_ff[`IRQ_RETRY_BIT];
  endproperty
  a_retry_irq: assert property (p_retry_irq) else $error("retry event lost"); // R15 R19

  property p_mgmt;
    MGMT_DONE_IN && !irq_mask_bits_ff[`IRQ_MGMT_DONE_BIT] |=> irq_source_flags_ff[`IRQ_MGMT_DONE_BIT];
  endproperty
  a_mgmt: assert property (p_mgmt) else $error("management done lost"); // R16 R19

  property p_reserved;
    (irq_source_flags_ff & ~`IRQ_VALID_MASK) == `IRQ_SOURCE_RST &&
      (irq_mask_bits_ff & ~`IRQ_VALID_MASK) == `IRQ_SOURCE_RST;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set"); // R17 R18

endmodule

`default_nettype wire

/* File: tb/testbench.sv */
// Purpose: self-checking bench for the MAC status and interrupt block
// Assumes: APB slave answers after one or more wait states; events are one-cycle pulses
// Notes: each access notes its expected answer in a queue, a monitor compares on PREADY_OUT
`timescale 1ns/100ps
`default_nettype none
`include "mac_irq_regs.svh"

module testbench;
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, tx_err, bad_crc, irq;
  mac_irq_pkg::addr_t paddr;
  mac_irq_pkg::word_t pwdata, prdata, r;
  logic [5:0] ev;
  logic [33:0] note;
  logic [33:0] q[$];
  logic [5:0] evs[5] = '{6'h01, 6'h02, 6'h08, 6'h10, 6'h20};
  int bits[5] = '{4, 5, 13, 12, 0};
  int miscompares, checked;

  ////////////////////////////////////////////////////////////////////////////
  // ev order: underrun, retry, collision, hold-off zero, pause rx, mgmt done
  mac_tx_status_and_irq_logic dut (
    .CLK_IN(clk), .ARST_N_IN(arst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PREADY_OUT(pready),
    .PRDATA_OUT(prdata), .PSLVERR_OUT(pslverr), .TX_UNDERRUN_IN(ev[0]),
    .RETRY_LIMIT_IN(ev[1]), .COLLISION_IN(ev[2]), .HOLD_OFF_ZERO_IN(ev[3]),
    .PAUSE_RX_IN(ev[4]), .MGMT_DONE_IN(ev[5]), .TX_ERR_OUT(tx_err),
    .FORCE_BAD_CRC_OUT(bad_crc), .ETH_IRQ_LINE_OUT(irq));

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp_word(input string what, input mac_irq_pkg::word_t exp, input mac_irq_pkg::word_t got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_bit(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // one apb transfer; hold drives event inputs through the whole access phase
  task automatic apb(input logic wr, input mac_irq_pkg::addr_t a, input mac_irq_pkg::word_t d,
                     input logic chk, input logic err, input logic [5:0] hold);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    q.push_back({chk, err, d});
    @(posedge clk);
    penable <= 1'b1;
    ev <= hold;
    // request stands until the edge that samples pready high; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    ev <= 6'h00;
  endtask

  task automatic wr(input mac_irq_pkg::addr_t a, input mac_irq_pkg::word_t d);
    apb(1'b1, a, d, 1'b0, 1'b0, 6'h00);
  endtask

  task automatic rd(input mac_irq_pkg::addr_t a, input mac_irq_pkg::word_t exp);
    apb(1'b0, a, exp, 1'b1, 1'b0, 6'h00);
  endtask

  // one-cycle event pulse, returns at the negedge where the flags are visible
  task automatic pulse(input logic [5:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 6'h00;
    @(negedge clk);
  endtask

  task automatic test_done(input string name);
    $display("test %s done", name);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // monitor: sampled values at the completing edge, before the slave updates
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      if (q.size() == 0) begin
        miscompares++;
        $display("wrong value apb note expected 1 seen 0");
      end else begin
        note = q.pop_front();
        cmp_bit("pslverr", note[32], pslverr);
        if (note[33]) begin
          cmp_word("prdata", note[31:0], prdata);
        end
      end
    end
  end

  // watchdog: the tests need well under a thousand cycles
  initial begin
    #80000;
    miscompares++;
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    ev = 6'h00;
    miscompares = 0;
    checked = 0;
    r = $urandom(32'h832d);
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // reset values, read-only mask, unmapped access
    rd(`IRQ_MASK_BITS_OFS, `IRQ_MASK_RST);
    rd(`IRQ_SOURCE_OFS, `IRQ_SOURCE_RST);
    rd(`TX_STATUS_OFS, `TX_STATUS_RST);
    rd(`IRQ_UNMASK_OFS, 32'h0000_0000);
    wr(`IRQ_MASK_BITS_OFS, 32'h0000_0000);
    rd(`IRQ_MASK_BITS_OFS, `IRQ_MASK_RST);
    apb(1'b0, 12'h100, 32'h0000_0000, 1'b1, 1'b1, 6'h00);
    cmp_bit("irq line", 1'b0, irq);
    test_done("reset");
    // underrun side effects, masked events, tx status w1c
    pulse(6'h01);
    cmp_bit("tx err", 1'b1, tx_err);
    cmp_bit("bad crc", 1'b1, bad_crc);
    @(negedge clk);
    cmp_bit("tx err", 1'b0, tx_err);
    pulse(6'h3e);
    cmp_bit("irq line", 1'b0, irq);
    rd(`IRQ_SOURCE_OFS, 32'h0000_0000);
    rd(`TX_STATUS_OFS, 32'h0000_0046);
    wr(`TX_STATUS_OFS, 32'h0000_0000);
    rd(`TX_STATUS_OFS, 32'h0000_0046);
    wr(`TX_STATUS_OFS, 32'h0000_0004);
    rd(`TX_STATUS_OFS, 32'h0000_0042);
    r = $urandom();
    wr(`TX_STATUS_OFS, r & `TX_VALID_MASK);
    rd(`TX_STATUS_OFS, 32'h0000_0042 & ~r);
    wr(`TX_STATUS_OFS, 32'h0000_0046);
    rd(`TX_STATUS_OFS, 32'h0000_0000);
    test_done("tx status");
    // unmask all, then each source in turn
    wr(`IRQ_UNMASK_OFS, `IRQ_VALID_MASK);
    rd(`IRQ_MASK_BITS_OFS, 32'h0000_0000);
    for (int i = 0; i < 5; i++) begin
      pulse(evs[i]);
      cmp_bit("irq line", 1'b1, irq);
      rd(`IRQ_SOURCE_OFS, 32'h0000_0001 << bits[i]);
      rd(`IRQ_SOURCE_OFS, 32'h0000_0000);
      @(negedge clk);
      cmp_bit("irq line", 1'b0, irq);
    end
    test_done("sources");
    // mask port sets only the chosen bits
    wr(`IRQ_MASK_OFS, 32'h0000_0011);
    rd(`IRQ_MASK_BITS_OFS, 32'h0000_0011);
    pulse(6'h11);
    rd(`IRQ_SOURCE_OFS, 32'h0000_1000);
    wr(`IRQ_MASK_OFS, 32'hffff_ffff);
    rd(`IRQ_MASK_BITS_OFS, `IRQ_MASK_RST);
    test_done("mask");
    // direct writes to interrupt status ignore the mask
    for (int i = 0; i < 4; i++) begin
      r = $urandom();
      wr(`IRQ_SOURCE_OFS, r & (32'hffff_c000 | `IRQ_VALID_MASK));
      @(negedge clk);
      cmp_bit("irq line", |(r & `IRQ_VALID_MASK), irq);
      rd(`IRQ_SOURCE_OFS, r & `IRQ_VALID_MASK);
      rd(`IRQ_SOURCE_OFS, 32'h0000_0000);
    end
    test_done("status write");
    // events held across a clearing access must survive it
    pulse(6'h04);
    apb(1'b1, `TX_STATUS_OFS, 32'h0000_0046, 1'b0, 1'b0, 6'h04);
    rd(`TX_STATUS_OFS, 32'h0000_0002);
    wr(`IRQ_UNMASK_OFS, 32'h0000_0001);
    apb(1'b1, `IRQ_SOURCE_OFS, 32'h0000_0000, 1'b0, 1'b0, 6'h20);
    rd(`IRQ_SOURCE_OFS, 32'h0000_0001);
    test_done("event wins");
    // let the monitor take the last note before counting what is left
    @(negedge clk);
    cmp_word("pending notes", 32'h0000_0000, 32'(q.size()));
    give_verdict();
  end
endmodule
`default_nettype wire
